//--- include/sfr_pkg.sv
// Register map, reset values and alternate-function bit positions
package sfr_pkg;
  localparam logic [7:0] ADDR_PORT0    = 8'h80;
  localparam logic [7:0] ADDR_STACK    = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LO  = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HI  = 8'h83;
  localparam logic [7:0] ADDR_PWR      = 8'h87;
  localparam logic [7:0] ADDR_TCTL     = 8'h88;
  localparam logic [7:0] ADDR_TMODE    = 8'h89;
  localparam logic [7:0] ADDR_T0_LO    = 8'h8A;
  localparam logic [7:0] ADDR_T1_LO    = 8'h8B;
  localparam logic [7:0] ADDR_T0_HI    = 8'h8C;
  localparam logic [7:0] ADDR_T1_HI    = 8'h8D;
  localparam logic [7:0] ADDR_PORT1    = 8'h90;
  localparam logic [7:0] ADDR_SCTL     = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER     = 8'h99;
  localparam logic [7:0] ADDR_PORT2    = 8'hA0;
  localparam logic [7:0] ADDR_IEN      = 8'hA8;
  localparam logic [7:0] ADDR_PORT3    = 8'hB0;
  localparam logic [7:0] ADDR_IPRI     = 8'hB8;
  localparam logic [7:0] ADDR_T2CTL    = 8'hC8;
  localparam logic [7:0] ADDR_RLD_LO   = 8'hCA;
  localparam logic [7:0] ADDR_RLD_HI   = 8'hCB;
  localparam logic [7:0] ADDR_T2_LO    = 8'hCC;
  localparam logic [7:0] ADDR_T2_HI    = 8'hCD;
  localparam logic [7:0] ADDR_PSW      = 8'hD0;
  localparam logic [7:0] ADDR_MAIN     = 8'hE0;
  localparam logic [7:0] ADDR_SCRATCH  = 8'hF0;
  localparam logic [7:0] STACK_RESET   = 8'h07;
  localparam logic [7:0] PORT_RESET    = 8'hFF;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // Timer 2 control bit positions
  localparam int T2_RUN_BIT = 2;
  localparam int T2_CAP_BIT = 0;
  localparam int T2_TRIG_EN_BIT = 3;
  // Port alternate-function bit positions
  localparam int P3_RXD = 0;
  localparam int P3_TXD = 1;
  localparam int P3_IRQ0 = 2;
  localparam int P3_IRQ1 = 3;
  localparam int P3_T0 = 4;
  localparam int P3_T1 = 5;
  localparam int P3_WR = 6;
  localparam int P3_RD = 7;
  localparam int P1_T2 = 0;
  localparam int P1_T2TRIG = 1;
endpackage : sfr_pkg

//--- include/timer2_if.sv
// Signals between the register bank and the timer 2 block
`timescale 1ns/1ps
interface timer2_if;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_rld_lo;
  logic       wr_rld_hi;
  logic [7:0] wdata;
  logic       run;
  logic       capture_mode;
  logic       trig_en;
  logic       trig_pin;
  logic [7:0] count_lo;
  logic [7:0] count_hi;
  logic [7:0] rld_lo;
  logic [7:0] rld_hi;
  logic       overflow;
  modport bank  (output wr_lo, wr_hi, wr_rld_lo, wr_rld_hi, wdata, run,
                 capture_mode, trig_en, trig_pin,
                 input count_lo, count_hi, rld_lo, rld_hi, overflow);
  modport timer (input wr_lo, wr_hi, wr_rld_lo, wr_rld_hi, wdata, run,
                 capture_mode, trig_en, trig_pin,
                 output count_lo, count_hi, rld_lo, rld_hi, overflow);
endinterface : timer2_if

//--- design/timer2_unit.sv
// Timer 2 count, capture and auto-reload pairs
`timescale 1ns/1ps
module timer2_unit (
  input wire logic clk,
  input wire logic rst_b,
  timer2_if.timer  t2
);
  import sfr_pkg::*;
  logic [15:0] count_q;
  logic [15:0] rld_q;
  logic        trig_q;
  logic        trig_fall;
  assign trig_fall = trig_q & ~t2.trig_pin;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trig_q <= 1'b1;
    end else begin
      trig_q <= t2.trig_pin;
    end
  end
  // Count pair software writes win over counting
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= 16'h0000;
    end else if (t2.wr_lo) begin
      count_q[7:0] <= t2.wdata;
    end else if (t2.wr_hi) begin
      count_q[15:8] <= t2.wdata;
    end else if (t2.run) begin
      if (!t2.capture_mode && (count_q == 16'hFFFF ||
          (t2.trig_en && trig_fall))) begin
        count_q <= rld_q;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end
  // Capture pair doubles as reload value
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rld_q <= 16'h0000;
    end else if (t2.wr_rld_lo) begin
      rld_q[7:0] <= t2.wdata;
    end else if (t2.wr_rld_hi) begin
      rld_q[15:8] <= t2.wdata;
    end else if (t2.capture_mode && t2.trig_en && trig_fall) begin
      rld_q <= count_q;
    end
  end
  assign t2.count_lo = count_q[7:0];
  assign t2.count_hi = count_q[15:8];
  assign t2.rld_lo   = rld_q[7:0];
  assign t2.rld_hi   = rld_q[15:8];
  assign t2.overflow = t2.run && count_q == 16'hFFFF;
endmodule : timer2_unit

//--- design/port_pins.sv
// One port's pin drive: latch, bus override and alternate function
`timescale 1ns/1ps
module port_pins #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input  wire logic [7:0] latch,
  input  wire logic [7:0] alt_out,
  input  wire logic       bus_sel,
  input  wire logic [7:0] bus_data,
  input  wire logic       bus_drive,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe
);
  always_comb begin
    if (bus_sel) begin
      pin_o  = bus_data;
      pin_oe = bus_drive ? 8'hFF : 8'h00;
    end else begin
      // Alternate output gated by the latch bit
      pin_o  = latch & alt_out;
      // Open-drain port releases a high bit; others pull up weakly
      pin_oe = OPEN_DRAIN ? ~pin_o : 8'hFF;
    end
  end
endmodule : port_pins

//--- design/sfr_bank.sv
// Special register space with port latches and pin sharing
`timescale 1ns/1ps
module sfr_bank
  import sfr_pkg::*;
#(
  parameter bit HAS_TIMER2 = 1'b1
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RST_B,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  input  wire logic       RMW,
  output logic      [7:0] RDATA,
  input  wire logic       PUSH,
  input  wire logic       POP,
  output logic      [7:0] STACK_PTR,
  input  wire logic       DATA_POINTER_WR,
  input  wire logic [15:0] DATA_POINTER_WDATA,
  input  wire logic       DATA_POINTER_INC,
  output logic     [15:0] DATA_POINTER,
  input  wire logic       MULDIV_WR,
  input  wire logic [7:0] MULDIV_DATA,
  output logic      [7:0] SCRATCH,
  output logic      [7:0] MAIN_OPERAND,
  output logic            TX_START,
  output logic      [7:0] TX_DATA,
  input  wire logic       RX_LOAD,
  input  wire logic [7:0] RX_DATA,
  input  wire logic       SERIAL_TX,
  input  wire logic       TIMER0_TICK,
  input  wire logic       TIMER1_TICK,
  output logic            SERIAL_RX,
  output logic            EXT_IRQ0,
  output logic            EXT_IRQ1,
  output logic            TIMER0_EXT,
  output logic            TIMER1_EXT,
  output logic            TIMER2_EXT,
  output logic            TIMER2_OVF,
  input  wire logic       XBUS_ACTIVE,
  input  wire logic       XBUS_WIDE,
  input  wire logic       XBUS_ADDR_PHASE,
  input  wire logic       XBUS_DATA_OUT,
  input  wire logic [15:0] XBUS_ADDR,
  input  wire logic [7:0] XBUS_WDATA,
  input  wire logic       XBUS_WR_STB,
  input  wire logic       XBUS_RD_STB,
  output logic      [7:0] XBUS_RDATA,
  input  wire logic [7:0] P0_I,
  output logic      [7:0] P0_O,
  output logic      [7:0] P0_OE,
  input  wire logic [7:0] P1_I,
  output logic      [7:0] P1_O,
  output logic      [7:0] P1_OE,
  input  wire logic [7:0] P2_I,
  output logic      [7:0] P2_O,
  output logic      [7:0] P2_OE,
  input  wire logic [7:0] P3_I,
  output logic      [7:0] P3_O,
  output logic      [7:0] P3_OE
);
  import sfr_pkg::*;

  timer2_if t2 ();

  logic [7:0]  port0_latch_q, port1_latch_q, port2_latch_q, port3_latch_q;
  logic [7:0]  stack_pointer_q;
  logic [15:0] data_pointer_q;
  logic [7:0]  power_control_q, timer_control_q, timer_mode_q;
  logic [15:0] timer0_q, timer1_q;
  logic [7:0]  serial_control_q, tx_buf_q, rx_buf_q, tx_start_q;
  logic [7:0]  interrupt_enable_q, interrupt_priority_q;
  logic [7:0]  timer2_control_q, psw_q, main_operand_q, scratch_q;
  logic [7:0]  rdata_d, rdata_q;
  logic [7:0]  p1_alt, p3_alt;

  function automatic logic wr_at(input logic [7:0] a);
    return WR && ADDR == a;
  endfunction : wr_at

  function automatic logic [7:0] port_view(input logic [7:0] latch,
                                           input logic [7:0] pins);
    return RMW ? latch : pins;
  endfunction : port_view

  // Port latches
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      port0_latch_q <= PORT_RESET;
      port1_latch_q <= PORT_RESET;
      port2_latch_q <= PORT_RESET;
      port3_latch_q <= PORT_RESET;
    end else begin
      if (XBUS_ACTIVE) begin
        port0_latch_q <= PORT_RESET;
      end else if (wr_at(ADDR_PORT0)) begin
        port0_latch_q <= WDATA;
      end
      if (wr_at(ADDR_PORT1)) begin
        port1_latch_q <= WDATA;
      end
      // Port 2 latch keeps its value across bus use
      if (wr_at(ADDR_PORT2)) begin
        port2_latch_q <= WDATA;
      end
      if (wr_at(ADDR_PORT3)) begin
        port3_latch_q <= WDATA;
      end
    end
  end

  // Stack pointer; pre-increment on push
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      stack_pointer_q <= STACK_RESET;
    end else if (wr_at(ADDR_STACK)) begin
      stack_pointer_q <= WDATA;
    end else if (PUSH) begin
      stack_pointer_q <= stack_pointer_q + 8'h01;
    end else if (POP) begin
      stack_pointer_q <= stack_pointer_q - 8'h01;
    end
  end

  // Data pointer, word or byte access
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      data_pointer_q <= 16'h0000;
    end else if (DATA_POINTER_WR) begin
      data_pointer_q <= DATA_POINTER_WDATA;
    end else if (wr_at(ADDR_DATA_POINTER_LO)) begin
      data_pointer_q[7:0] <= WDATA;
    end else if (wr_at(ADDR_DATA_POINTER_HI)) begin
      data_pointer_q[15:8] <= WDATA;
    end else if (DATA_POINTER_INC) begin
      data_pointer_q <= data_pointer_q + 16'h0001;
    end
  end

  // Timers 0 and 1 count pairs; they count here on ticks that come from elsewhere
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      timer0_q <= 16'h0000;
      timer1_q <= 16'h0000;
    end else begin
      if (wr_at(ADDR_T0_LO)) begin
        timer0_q[7:0] <= WDATA;
      end else if (wr_at(ADDR_T0_HI)) begin
        timer0_q[15:8] <= WDATA;
      end else if (TIMER0_TICK) begin
        timer0_q <= timer0_q + 16'h0001;
      end
      if (wr_at(ADDR_T1_LO)) begin
        timer1_q[7:0] <= WDATA;
      end else if (wr_at(ADDR_T1_HI)) begin
        timer1_q[15:8] <= WDATA;
      end else if (TIMER1_TICK) begin
        timer1_q <= timer1_q + 16'h0001;
      end
    end
  end

  // Serial buffer: write side and read side are separate
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      tx_buf_q   <= REG_RESET;
      tx_start_q <= REG_RESET;
      rx_buf_q   <= REG_RESET;
    end else begin
      tx_start_q <= {7'h00, wr_at(ADDR_SERIAL_BUFFER)};
      if (wr_at(ADDR_SERIAL_BUFFER)) begin
        tx_buf_q <= WDATA;
      end
      if (RX_LOAD) begin
        rx_buf_q <= RX_DATA;
      end
    end
  end

  // Control and operand registers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      power_control_q      <= REG_RESET;
      timer_control_q      <= REG_RESET;
      timer_mode_q         <= REG_RESET;
      serial_control_q     <= REG_RESET;
      interrupt_enable_q   <= REG_RESET;
      interrupt_priority_q <= REG_RESET;
      timer2_control_q     <= REG_RESET;
      psw_q                <= REG_RESET;
      main_operand_q       <= REG_RESET;
      scratch_q            <= REG_RESET;
    end else begin
      if (wr_at(ADDR_PWR))   power_control_q      <= WDATA;
      if (wr_at(ADDR_TCTL))  timer_control_q      <= WDATA;
      if (wr_at(ADDR_TMODE)) timer_mode_q         <= WDATA;
      if (wr_at(ADDR_SCTL))  serial_control_q     <= WDATA;
      if (wr_at(ADDR_IEN))   interrupt_enable_q   <= WDATA;
      if (wr_at(ADDR_IPRI))  interrupt_priority_q <= WDATA;
      if (wr_at(ADDR_PSW))   psw_q                <= WDATA;
      if (wr_at(ADDR_MAIN))  main_operand_q       <= WDATA;
      if (HAS_TIMER2 && wr_at(ADDR_T2CTL)) begin
        timer2_control_q <= WDATA;
      end
      if (MULDIV_WR) begin
        scratch_q <= MULDIV_DATA;
      end else if (wr_at(ADDR_SCRATCH)) begin
        scratch_q <= WDATA;
      end
    end
  end

  // Timer 2, present only on the larger variant
  assign t2.wdata        = WDATA;
  assign t2.wr_lo        = HAS_TIMER2 && wr_at(ADDR_T2_LO);
  assign t2.wr_hi        = HAS_TIMER2 && wr_at(ADDR_T2_HI);
  assign t2.wr_rld_lo    = HAS_TIMER2 && wr_at(ADDR_RLD_LO);
  assign t2.wr_rld_hi    = HAS_TIMER2 && wr_at(ADDR_RLD_HI);
  assign t2.run          = timer2_control_q[T2_RUN_BIT];
  assign t2.capture_mode = timer2_control_q[T2_CAP_BIT];
  assign t2.trig_en      = timer2_control_q[T2_TRIG_EN_BIT];
  // Trigger seen at the pin, gated by latch via pin level
  assign t2.trig_pin     = HAS_TIMER2 ? P1_I[P1_T2TRIG] : 1'b1;

  timer2_unit u_timer2 (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .t2    (t2.timer)
  );

  // Read mux; unmapped addresses return a fixed value
  always_comb begin
    case (ADDR)
      ADDR_PORT0:   rdata_d = port_view(port0_latch_q, P0_I);
      ADDR_PORT1:   rdata_d = port_view(port1_latch_q, P1_I);
      ADDR_PORT2:   rdata_d = port_view(port2_latch_q, P2_I);
      ADDR_PORT3:   rdata_d = port_view(port3_latch_q, P3_I);
      ADDR_STACK:   rdata_d = stack_pointer_q;
      ADDR_DATA_POINTER_LO: rdata_d = data_pointer_q[7:0];
      ADDR_DATA_POINTER_HI: rdata_d = data_pointer_q[15:8];
      ADDR_PWR:     rdata_d = power_control_q;
      ADDR_TCTL:    rdata_d = timer_control_q;
      ADDR_TMODE:   rdata_d = timer_mode_q;
      ADDR_T0_LO:   rdata_d = timer0_q[7:0];
      ADDR_T1_LO:   rdata_d = timer1_q[7:0];
      ADDR_T0_HI:   rdata_d = timer0_q[15:8];
      ADDR_T1_HI:   rdata_d = timer1_q[15:8];
      ADDR_SCTL:    rdata_d = serial_control_q;
      ADDR_SERIAL_BUFFER:    rdata_d = rx_buf_q;
      ADDR_IEN:     rdata_d = interrupt_enable_q;
      ADDR_IPRI:    rdata_d = interrupt_priority_q;
      ADDR_PSW:     rdata_d = psw_q;
      ADDR_MAIN:    rdata_d = main_operand_q;
      ADDR_SCRATCH: rdata_d = scratch_q;
      ADDR_T2CTL:   rdata_d = HAS_TIMER2 ? timer2_control_q : UNMAPPED_DATA;
      ADDR_RLD_LO:  rdata_d = HAS_TIMER2 ? t2.rld_lo : UNMAPPED_DATA;
      ADDR_RLD_HI:  rdata_d = HAS_TIMER2 ? t2.rld_hi : UNMAPPED_DATA;
      ADDR_T2_LO:   rdata_d = HAS_TIMER2 ? t2.count_lo : UNMAPPED_DATA;
      ADDR_T2_HI:   rdata_d = HAS_TIMER2 ? t2.count_hi : UNMAPPED_DATA;
      // Zero keeps any later bit here inactive
      default:      rdata_d = UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      rdata_q <= REG_RESET;
    end else if (RD) begin
      rdata_q <= rdata_d;
    end
  end

  // Alternate outputs; inputs-only functions leave the latch in charge
  always_comb begin
    p3_alt         = 8'hFF;
    p3_alt[P3_TXD] = SERIAL_TX;
    p3_alt[P3_WR]  = ~XBUS_WR_STB;
    p3_alt[P3_RD]  = ~XBUS_RD_STB;
    p1_alt         = 8'hFF;
  end

  // Port 0: address then data; port 2 high address only when wide
  port_pins #(.OPEN_DRAIN(1'b1)) u_port0 (
    .latch     (port0_latch_q),
    .alt_out   (8'hFF),
    .bus_sel   (XBUS_ACTIVE),
    .bus_data  (XBUS_ADDR_PHASE ? XBUS_ADDR[7:0] : XBUS_WDATA),
    .bus_drive (XBUS_ADDR_PHASE || XBUS_DATA_OUT),
    .pin_o     (P0_O),
    .pin_oe    (P0_OE)
  );
  port_pins #(.OPEN_DRAIN(1'b0)) u_port1 (
    .latch     (port1_latch_q),
    .alt_out   (p1_alt),
    .bus_sel   (1'b0),
    .bus_data  (8'h00),
    .bus_drive (1'b0),
    .pin_o     (P1_O),
    .pin_oe    (P1_OE)
  );
  port_pins #(.OPEN_DRAIN(1'b0)) u_port2 (
    .latch     (port2_latch_q),
    .alt_out   (8'hFF),
    .bus_sel   (XBUS_ACTIVE && XBUS_WIDE),
    .bus_data  (XBUS_ADDR[15:8]),
    .bus_drive (1'b1),
    .pin_o     (P2_O),
    .pin_oe    (P2_OE)
  );
  port_pins #(.OPEN_DRAIN(1'b0)) u_port3 (
    .latch     (port3_latch_q),
    .alt_out   (p3_alt),
    .bus_sel   (1'b0),
    .bus_data  (8'h00),
    .bus_drive (1'b0),
    .pin_o     (P3_O),
    .pin_oe    (P3_OE)
  );

  // Alternate inputs see the true pin level, except TIMER2_EXT, which is tied low without timer 2
  assign SERIAL_RX   = P3_I[P3_RXD];
  assign EXT_IRQ0    = P3_I[P3_IRQ0];
  assign EXT_IRQ1    = P3_I[P3_IRQ1];
  assign TIMER0_EXT  = P3_I[P3_T0];
  assign TIMER1_EXT  = P3_I[P3_T1];
  assign TIMER2_EXT  = HAS_TIMER2 ? P1_I[P1_T2] : 1'b0;
  assign TIMER2_OVF  = HAS_TIMER2 && t2.overflow;
  assign XBUS_RDATA  = P0_I;
  assign RDATA       = rdata_q;
  assign STACK_PTR   = stack_pointer_q;
  assign DATA_POINTER        = data_pointer_q;
  assign SCRATCH     = scratch_q;
  assign MAIN_OPERAND = main_operand_q;
  assign TX_START    = tx_start_q[0];
  assign TX_DATA     = tx_buf_q;
endmodule : sfr_bank

//--- verif/sfr_bank_chk.sv
// Port-level assertions for the special register bank
`timescale 1ns/1ps
module sfr_bank_chk
  import sfr_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RST_B,
  input wire logic [7:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic        PUSH,
  input wire logic        POP,
  input wire logic [7:0]  STACK_PTR,
  input wire logic        DATA_POINTER_WR,
  input wire logic [15:0] DATA_POINTER_WDATA,
  input wire logic [15:0] DATA_POINTER,
  input wire logic        TX_START,
  input wire logic [7:0]  TX_DATA,
  input wire logic        XBUS_ACTIVE,
  input wire logic        XBUS_WIDE,
  input wire logic        XBUS_ADDR_PHASE,
  input wire logic [15:0] XBUS_ADDR,
  input wire logic [7:0]  P0_O,
  input wire logic [7:0]  P2_O
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  AST_SP_RESET: assert property (
    $rose(RST_B) |-> STACK_PTR == STACK_RESET)
    else $error("stack pointer not at reset value");
  AST_PUSH_INC: assert property (
    PUSH && !POP && !WR |=> STACK_PTR == $past(STACK_PTR) + 8'h01)
    else $error("stack pointer not incremented by push");
  AST_DATA_POINTER_LOAD: assert property (
    DATA_POINTER_WR && !WR |=> DATA_POINTER == $past(DATA_POINTER_WDATA))
    else $error("data pointer not loaded as one word");
  AST_TX_START: assert property (
    WR && ADDR == ADDR_SERIAL_BUFFER |=> TX_START && TX_DATA == $past(WDATA))
    else $error("serial buffer write did not start a send");
  AST_UNMAPPED: assert property (
    RD && ADDR == 8'h84 |=> RDATA == UNMAPPED_DATA)
    else $error("unmapped read returned a stored value");
  AST_RD_STACK: assert property (
    RD && ADDR == ADDR_STACK |=> RDATA == $past(STACK_PTR))
    else $error("stack pointer read data wrong");
  AST_P2_HIGH: assert property (
    XBUS_ACTIVE && XBUS_WIDE |-> P2_O == XBUS_ADDR[15:8])
    else $error("port 2 not showing high address");
  AST_P0_LOW: assert property (
    XBUS_ACTIVE && XBUS_ADDR_PHASE |-> P0_O == XBUS_ADDR[7:0])
    else $error("port 0 not showing low address");
endmodule : sfr_bank_chk

bind sfr_bank sfr_bank_chk sfr_bank_chk_inst (
  .CORE_CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .PUSH, .POP,
  .STACK_PTR, .DATA_POINTER_WR, .DATA_POINTER_WDATA, .DATA_POINTER, .TX_START, .TX_DATA,
  .XBUS_ACTIVE, .XBUS_WIDE, .XBUS_ADDR_PHASE, .XBUS_ADDR, .P0_O, .P2_O
);

//--- verif/ext_pins_model.sv
// Pin-side model: pull-ups, open-drain port 0 and external memory
`timescale 1ns/1ps
module ext_pins_model (
  input  wire logic       CORE_CLK,
  input  wire logic [7:0] P0_O,
  input  wire logic [7:0] P0_OE,
  input  wire logic [7:0] P1_O,
  input  wire logic [7:0] P1_OE,
  input  wire logic [7:0] P2_O,
  input  wire logic [7:0] P2_OE,
  input  wire logic [7:0] P3_O,
  input  wire logic [7:0] P3_OE,
  input  wire logic [7:0] mem_data,
  input  wire logic [7:0] mem_drive,
  input  wire logic [7:0] low1,
  input  wire logic [7:0] low3,
  output logic      [7:0] P0_I,
  output logic      [7:0] P1_I,
  output logic      [7:0] P2_I,
  output logic      [7:0] P3_I
);
  logic [7:0] last_q = 8'h00;
  // No pull-up on port 0, so a floating bit must not look stable
  assign P0_I = (P0_OE & P0_O) | (~P0_OE & mem_drive & mem_data)
              | (~P0_OE & ~mem_drive & ~last_q);
  // Weak pull-ups; an external low always wins
  assign P1_I = ((P1_OE & P1_O) | ~P1_OE) & ~low1;
  assign P2_I = (P2_OE & P2_O) | ~P2_OE;
  assign P3_I = ((P3_OE & P3_O) | ~P3_OE) & ~low3;
  always @(posedge CORE_CLK) begin
    last_q <= P0_I;
  end
endmodule : ext_pins_model

//--- verif/sfr_bank_tb.sv
// Self-checking bench for the special register bank
`timescale 1ns/1ps
module sfr_bank_tb;
  import sfr_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, RX_DATA = 8'h00;
  logic [7:0]  MULDIV_DATA = 8'h00, XBUS_WDATA = 8'h00, low3 = 8'h00;
  logic [7:0]  mem_data = 8'h00, mem_drive = 8'h00, low1 = 8'h00;
  logic [15:0] DATA_POINTER_WDATA = 16'h0000, XBUS_ADDR = 16'h0000;
  logic WR = 1'b0, RD = 1'b0, RMW = 1'b0, PUSH = 1'b0, POP = 1'b0;
  logic DATA_POINTER_WR = 1'b0, DATA_POINTER_INC = 1'b0, MULDIV_WR = 1'b0;
  logic RX_LOAD = 1'b0, SERIAL_TX = 1'b1, TIMER0_TICK = 1'b0;
  logic TIMER1_TICK = 1'b0, XBUS_ACTIVE = 1'b0, XBUS_WIDE = 1'b0;
  logic XBUS_ADDR_PHASE = 1'b0, XBUS_DATA_OUT = 1'b0;
  logic XBUS_WR_STB = 1'b0, XBUS_RD_STB = 1'b0;
  logic [7:0]  RDATA, STACK_PTR, SCRATCH, MAIN_OPERAND, TX_DATA;
  logic [7:0]  XBUS_RDATA, P0_I, P0_O, P0_OE, P1_I, P1_O, P1_OE;
  logic [7:0]  P2_I, P2_O, P2_OE, P3_I, P3_O, P3_OE;
  logic [15:0] DATA_POINTER;
  logic TX_START, SERIAL_RX, EXT_IRQ0, EXT_IRQ1, TIMER0_EXT;
  logic TIMER1_EXT, TIMER2_EXT, TIMER2_OVF;
  int   errors = 0;
  int   check_count = 0;

  sfr_bank #(.HAS_TIMER2(1'b1)) sfr_bank_inst (
    .CORE_CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RMW, .RDATA, .PUSH, .POP,
    .STACK_PTR, .DATA_POINTER_WR, .DATA_POINTER_WDATA, .DATA_POINTER_INC, .DATA_POINTER, .MULDIV_WR,
    .MULDIV_DATA, .SCRATCH, .MAIN_OPERAND, .TX_START, .TX_DATA, .RX_LOAD,
    .RX_DATA, .SERIAL_TX, .TIMER0_TICK, .TIMER1_TICK, .SERIAL_RX,
    .EXT_IRQ0, .EXT_IRQ1, .TIMER0_EXT, .TIMER1_EXT, .TIMER2_EXT,
    .TIMER2_OVF, .XBUS_ACTIVE, .XBUS_WIDE, .XBUS_ADDR_PHASE,
    .XBUS_DATA_OUT, .XBUS_ADDR, .XBUS_WDATA, .XBUS_WR_STB, .XBUS_RD_STB,
    .XBUS_RDATA, .P0_I, .P0_O, .P0_OE, .P1_I, .P1_O, .P1_OE, .P2_I, .P2_O,
    .P2_OE, .P3_I, .P3_O, .P3_OE
  );
  ext_pins_model ext_pins_model_inst (
    .CORE_CLK, .P0_O, .P0_OE, .P1_O, .P1_OE, .P2_O, .P2_OE, .P3_O, .P3_OE,
    .mem_data, .mem_drive, .low1, .low3, .P0_I, .P1_I, .P2_I, .P3_I
  );
  always #2.5 CORE_CLK = ~CORE_CLK;

  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask : wr
  // Read data stand from the cycle after the strobe until the next read strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic m);
    @(posedge CORE_CLK);
    {ADDR, RMW, RD} <= {a, m, 1'b1};
    @(posedge CORE_CLK);
    {RMW, RD} <= 2'b00;
    #1 chk("RDATA", {8'h00, e}, {8'h00, RDATA});
  endtask : rd
  task automatic t_map();
    logic [7:0] tbl [21] = '{ADDR_STACK, ADDR_DATA_POINTER_LO, ADDR_DATA_POINTER_HI,
      ADDR_PWR, ADDR_TCTL, ADDR_TMODE, ADDR_T0_LO, ADDR_T1_LO, ADDR_T0_HI,
      ADDR_T1_HI, ADDR_SCTL, ADDR_IEN, ADDR_IPRI, ADDR_T2CTL, ADDR_RLD_LO,
      ADDR_RLD_HI, ADDR_T2_LO, ADDR_T2_HI, ADDR_PSW, ADDR_MAIN,
      ADDR_SCRATCH};
    rd(ADDR_STACK, STACK_RESET, 1'b0);
    rd(ADDR_PORT3, PORT_RESET, 1'b1);
    rd(ADDR_IEN, REG_RESET, 1'b0);
    foreach (tbl[i]) wr(tbl[i], tbl[i] ^ 8'h5A);
    foreach (tbl[i]) rd(tbl[i], tbl[i] ^ 8'h5A, 1'b0);
    chk("DATA_POINTER", 16'hD9D8, DATA_POINTER);
    chk("OPERANDS", 16'hBAAA, {MAIN_OPERAND, SCRATCH});
    wr(8'h84, 8'h00);
    rd(ADDR_DATA_POINTER_HI, 8'hD9, 1'b0);
    rd(8'h84, UNMAPPED_DATA, 1'b0);
  endtask : t_map
  task automatic t_ser_ptr();
    wr(ADDR_SERIAL_BUFFER, 8'hA5);
    #1 chk("TX", 16'h01A5, {7'h00, TX_START, TX_DATA});
    @(posedge CORE_CLK);
    {RX_DATA, RX_LOAD} <= {8'h3C, 1'b1};
    @(posedge CORE_CLK);
    RX_LOAD <= 1'b0;
    rd(ADDR_SERIAL_BUFFER, 8'h3C, 1'b0);
    wr(ADDR_STACK, 8'hFF);
    @(posedge CORE_CLK);
    {PUSH, DATA_POINTER_WR, MULDIV_WR} <= 3'b111;
    {DATA_POINTER_WDATA, MULDIV_DATA} <= 24'h12FFC3;
    @(posedge CORE_CLK);
    {PUSH, DATA_POINTER_WR, MULDIV_WR, POP, DATA_POINTER_INC} <= 5'b00011;
    TIMER0_TICK <= 1'b1;
    #1 chk("STACK_PTR", 16'h0000, {8'h00, STACK_PTR});
    @(posedge CORE_CLK);
    {POP, DATA_POINTER_INC, TIMER0_TICK} <= 3'b000;
    #1 chk("STACK_PTR", 16'h00FF, {8'h00, STACK_PTR});
    chk("DATA_POINTER", 16'h1300, DATA_POINTER);
    rd(ADDR_DATA_POINTER_HI, 8'h13, 1'b0);
    rd(ADDR_SCRATCH, 8'hC3, 1'b0);
    rd(ADDR_T0_LO, 8'hD1, 1'b0);
  endtask : t_ser_ptr
  task automatic t_bus();
    wr(ADDR_PORT0, 8'h00);
    wr(ADDR_PORT2, 8'h5C);
    @(posedge CORE_CLK);
    {XBUS_ACTIVE, XBUS_WIDE, XBUS_ADDR_PHASE} <= 3'b111;
    XBUS_ADDR <= 16'hABCD;
    #1 chk("P2P0", 16'hABCD, {P2_O, P0_O});
    @(posedge CORE_CLK);
    {XBUS_ADDR_PHASE, XBUS_DATA_OUT, XBUS_WR_STB} <= 3'b011;
    XBUS_WDATA <= 8'h96;
    #1 chk("P0", 16'hFF96, {P0_OE, P0_O});
    chk("WR_PIN", 16'h0000, {15'h0, P3_O[P3_WR]});
    @(posedge CORE_CLK);
    {XBUS_DATA_OUT, XBUS_WR_STB, XBUS_RD_STB} <= 3'b001;
    {mem_drive, mem_data} <= 16'hFF71;
    #1 chk("RD_IN", 16'h7100, {XBUS_RDATA, 7'h0, P3_O[P3_RD]});
    @(posedge CORE_CLK);
    {XBUS_ACTIVE, XBUS_WIDE, XBUS_RD_STB, mem_drive} <= 11'h000;
    rd(ADDR_PORT0, PORT_RESET, 1'b1);
    rd(ADDR_PORT2, 8'h5C, 1'b1);
    chk("P2_O", 16'h005C, {8'h00, P2_O});
  endtask : t_bus
  task automatic t_alt();
    wr(ADDR_PORT3, 8'hFD);
    #1 chk("TXD", 16'h0000, {15'h0, P3_O[P3_TXD]});
    wr(ADDR_PORT3, 8'hFF);
    #1 chk("TXD", 16'h0001, {15'h0, P3_O[P3_TXD]});
    @(posedge CORE_CLK);
    {SERIAL_TX, low3, low1} <= 17'h01501;
    #1 chk("TXD", 16'h0000, {15'h0, P3_O[P3_TXD]});
    chk("ALT_IN", 16'h000A, {10'h0, SERIAL_RX, EXT_IRQ0, EXT_IRQ1,
        TIMER0_EXT, TIMER1_EXT, TIMER2_EXT});
    rd(ADDR_PORT1, 8'hFE, 1'b0);
    rd(ADDR_PORT1, 8'hFF, 1'b1);
    @(posedge CORE_CLK);
    low1 <= 8'h00;
    wr(ADDR_T2_LO, 8'h34);
    wr(ADDR_T2_HI, 8'h12);
    wr(ADDR_T2CTL, 8'h09);
    @(posedge CORE_CLK);
    low1 <= 8'h02;
    repeat (3) @(posedge CORE_CLK);
    rd(ADDR_RLD_LO, 8'h34, 1'b0);
    rd(ADDR_RLD_HI, 8'h12, 1'b0);
    wr(ADDR_T2_LO, 8'hFE);
    wr(ADDR_T2_HI, 8'hFF);
    wr(ADDR_T2CTL, 8'h04);
    @(posedge CORE_CLK);
    #1 chk("T2_OVF", 16'h0001, {15'h0, TIMER2_OVF});
    // Reload to 1234, then one more count before the stop lands
    wr(ADDR_T2CTL, 8'h00);
    rd(ADDR_T2_HI, 8'h12, 1'b0);
    rd(ADDR_T2_LO, 8'h35, 1'b0);
  endtask : t_alt
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial begin
    repeat (12) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    t_map();
    t_ser_ptr();
    t_bus();
    t_alt();
    complete_run();
  end
endmodule : sfr_bank_tb
